// >>> hdl/rais_pkg.sv
// package: register map, field layout and event bundle of the receive alarm interrupt status block
package rais_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_STATUS = 10'h057;
  localparam logic [9:0] IDX_ENABLE = 10'h058;
  localparam logic [9:0] IDX_CLEAR = 10'h059;
  localparam logic [9:0] IDX_CTRL = 10'h05A;
  localparam logic [9:0] IDX_STATE = 10'h05B;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int EVT_W = 14;
  localparam int BIT_OVR_LO = 10;
  localparam int BIT_FRM_CLR = 9;
  localparam int BIT_FRM_SET = 8;
  localparam int BIT_DLN_CLR_LO = 4;
  localparam int BIT_DLN_SET_LO = 0;
  localparam int BIT_CTRL_CONCAT = 0;
  localparam int NUM_CHAN = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [EVT_W-1:0] RST_STATUS = 14'h0000;
  localparam logic [EVT_W-1:0] RST_ENABLE = 14'h0000;
  localparam logic RST_CONCAT = 1'b0;

  // bits that stay meaningful in concatenated single-channel mode
  localparam logic [EVT_W-1:0] CONCAT_VALID = 14'h0711;

  // ----------------------------------------
  // event bundle, packed in status bit order 13..0
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] port_rx_overrun;
    logic frame_loss_cleared;
    logic frame_loss_raised;
    logic [3:0] cellproc_delin_cleared;
    logic [3:0] cellproc_delin_raised;
  } rais_evt_t;

  // live alarm states, for the state register
  typedef struct packed {
    logic frame_loss_state;
    logic [3:0] cell_delineation_loss_state;
  } rais_state_t;

endpackage

// >>> hdl/rais_edge_detect.sv
// module: entry and exit detection on alarm state levels
`timescale 1ns/100ps
module rais_edge_detect #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // state levels
  input wire logic [W-1:0] state_lvl,
  // entry pulses
  output logic [W-1:0] entered_set,
  output logic [W-1:0] entered_reset,
  output logic armed
);

  logic [W-1:0] prev_reg;
  logic armed_reg;

  // ----------------------------------------
  // history
  // ----------------------------------------
  // the first cycle after reset only loads history, so a state already
  // high at release is not taken for a fresh entry
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= state_lvl;
    end
  end

  // ----------------------------------------
  // entry pulses
  // ----------------------------------------
  assign entered_set = armed_reg ? (state_lvl & ~prev_reg) : '0;
  assign entered_reset = armed_reg ? (~state_lvl & prev_reg) : '0;
  assign armed = armed_reg;

endmodule

// >>> hdl/rais_top.sv
// module: receive alarm interrupt status with a classic wishbone register slave
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/100ps

// Functional notes
// - per-port rx fifo overrun sets status bits 13..10 for ports 3..0.
// - a status bit raises the interrupt only when its enable bit is set.
// - frame loss machine entering reset (in-frame) sets status bit 9.
// - frame loss machine entering set (alarm) sets status bit 8.
// - delineation machine 3..0 entering reset sets status bits 7..4.
// - delineation machine 3..0 entering set sets status bits 3..0.
// - concatenated mode: overrun and delineation bits of channels 1..3 are invalid.
// - port 0 overrun, frame loss and processor 0 bits stay valid in both modes.
module rais_top #(
  parameter int ADR_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // alarm sources
  input wire logic [3:0] port_rx_overrun,
  input wire logic frame_loss_state,
  input wire logic [3:0] cell_delineation_loss_state,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [9:0] idx);
    return (adr[1:0] == 2'h0) && (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [rais_pkg::EVT_W-1:0] status_reg;
  logic [rais_pkg::EVT_W-1:0] status_next;
  logic [rais_pkg::EVT_W-1:0] enable_reg;
  logic concat_reg;
  logic [rais_pkg::EVT_W-1:0] valid_bits;
  logic [rais_pkg::EVT_W-1:0] clr_bits;
  logic [rais_pkg::EVT_W-1:0] set_bits;
  logic [31:0] wmask;
  logic req;
  logic wr_fire;
  logic [4:0] ent_set;
  logic [4:0] ent_reset;
  logic edge_armed;
  rais_pkg::rais_evt_t evt;
  rais_pkg::rais_state_t live;

  // ----------------------------------------
  // event capture
  // ----------------------------------------
  assign live.frame_loss_state = frame_loss_state;
  assign live.cell_delineation_loss_state = cell_delineation_loss_state;

  rais_edge_detect #(
    .W(5)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .state_lvl(live),
    .entered_set(ent_set),
    .entered_reset(ent_reset),
    .armed(edge_armed)
  );

  assign evt.port_rx_overrun = port_rx_overrun;
  assign evt.frame_loss_cleared = ent_reset[4];
  assign evt.frame_loss_raised = ent_set[4];
  assign evt.cellproc_delin_cleared = ent_reset[3:0];
  assign evt.cellproc_delin_raised = ent_set[3:0];

  // channels 1..3 do not exist in concatenated mode, so their bits are
  // never set there rather than left to float with stale sources
  assign valid_bits = concat_reg ? rais_pkg::CONCAT_VALID : '1;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // one wait state: ack rises the edge after the request, and writes land
  // on the edge where the master samples ack, as classic cycles expect
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_reg;
  assign wmask = lane_mask(wb_sel_i);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (req & ~ack_reg & ~wb_we_i) begin
      if (hit(wb_adr_i, rais_pkg::IDX_STATUS)) begin
        rdata_reg <= 32'(status_reg);
      end else if (hit(wb_adr_i, rais_pkg::IDX_ENABLE)) begin
        rdata_reg <= 32'(enable_reg);
      end else if (hit(wb_adr_i, rais_pkg::IDX_CTRL)) begin
        rdata_reg <= 32'(concat_reg);
      end else if (hit(wb_adr_i, rais_pkg::IDX_STATE)) begin
        rdata_reg <= 32'(live);
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      enable_reg <= rais_pkg::RST_ENABLE;
    end else if (wr_fire && hit(wb_adr_i, rais_pkg::IDX_ENABLE)) begin
      enable_reg <= (enable_reg & ~wmask[rais_pkg::EVT_W-1:0])
                  | (wb_dat_i[rais_pkg::EVT_W-1:0] & wmask[rais_pkg::EVT_W-1:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      concat_reg <= rais_pkg::RST_CONCAT;
    end else if (wr_fire && hit(wb_adr_i, rais_pkg::IDX_CTRL) && wb_sel_i[0]) begin
      concat_reg <= wb_dat_i[rais_pkg::BIT_CTRL_CONCAT];
    end
  end

  // ----------------------------------------
  // sticky status
  // ----------------------------------------
  assign clr_bits = (wr_fire && hit(wb_adr_i, rais_pkg::IDX_CLEAR))
                  ? (wb_dat_i[rais_pkg::EVT_W-1:0] & wmask[rais_pkg::EVT_W-1:0]) : '0;
  assign set_bits = evt & valid_bits;

  // a set in the clearing cycle wins, so no event is lost
  assign status_next = (status_reg & ~clr_bits) | set_bits;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_reg <= rais_pkg::RST_STATUS;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  assign irq = |(status_reg & enable_reg);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_clear_bit(int b);
    wr_fire && hit(wb_adr_i, rais_pkg::IDX_CLEAR) && wb_dat_i[b] && wb_sel_i[b/8];
  endsequence

  sequence s_frame_entry_reset;
    edge_armed && $past(frame_loss_state) && !frame_loss_state;
  endsequence

  sequence s_frame_entry_set;
    edge_armed && !$past(frame_loss_state) && frame_loss_state;
  endsequence

  a_overrun_port3: assert property (
    port_rx_overrun[3] && !concat_reg |=> status_reg[13])
    else $error("port 3 overrun did not set bit 13");

  a_mask_gates_irq: assert property (
    status_reg != '0 && (status_reg & enable_reg) == '0 |-> !irq)
    else $error("interrupt raised from a masked bit");

  a_enabled_irq: assert property (
    status_reg[8] && enable_reg[8] |-> irq)
    else $error("enabled status bit gave no interrupt");

  a_frame_reset_entry: assert property (
    s_frame_entry_reset |=> status_reg[9])
    else $error("frame loss exit did not set bit 9");

  a_frame_set_entry: assert property (
    s_frame_entry_set |=> status_reg[8])
    else $error("frame loss entry did not set bit 8");

  a_delin_reset_entry: assert property (
    edge_armed && $past(cell_delineation_loss_state[3]) && !cell_delineation_loss_state[3]
    && !concat_reg |=> status_reg[7])
    else $error("delineation 3 exit did not set bit 7");

  a_delin_set_entry: assert property (
    edge_armed && !$past(cell_delineation_loss_state[0]) && cell_delineation_loss_state[0]
    |=> status_reg[0])
    else $error("delineation 0 entry did not set bit 0");

  a_concat_blocks_ch1: assert property (
    concat_reg && !status_reg[11] && !status_reg[1] |=> !status_reg[11] && !status_reg[1])
    else $error("channel 1 bit set in concatenated mode");

  a_concat_keeps_ch0: assert property (
    concat_reg && port_rx_overrun[0] |=> status_reg[10])
    else $error("port 0 overrun lost in concatenated mode");

  a_sticky_hold: assert property (
    status_reg[9] && !clr_bits[9] |=> status_reg[9])
    else $error("status bit 9 dropped without a clear");

  a_clear_works: assert property (
    s_clear_bit(4) ##0 !evt.cellproc_delin_cleared[0] |=> !status_reg[4])
    else $error("clear write left bit 4 set");

  a_bus_ack_once: assert property (
    req && !ack_reg |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after one wait state");

endmodule

// >>> dv/rais_testbench.sv
// testbench: drives bus and alarm inputs of the receive alarm interrupt status block
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic sys_clk;
  logic rst_b;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] port_rx_overrun;
  logic frame_loss_state;
  logic [3:0] cell_delineation_loss_state;
  logic irq;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  int failures;
  int check_count;

  rais_top #(.ADR_W(12)) i_rais_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_rx_overrun(port_rx_overrun), .frame_loss_state(frame_loss_state),
    .cell_delineation_loss_state(cell_delineation_loss_state), .irq(irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // compare and verdict
  // ----------------------------------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_irq(input logic exp);
    compare({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic summarize;
    // a read whose answer never came leaves its note behind
    if (exp_q.size() != 0) failures++;
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // bus and alarm drivers
  // ----------------------------------------
  // request held until ack is sampled high, then one idle cycle
  task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wb_read(input logic [9:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_xfer(1'b0, idx, 32'h0);
  endtask

  task automatic clear_all;
    wb_xfer(1'b1, rais_pkg::IDX_CLEAR, 32'h3FFF);
  endtask

  // overrun is a one-cycle pulse; state levels stay where they are put
  task automatic pulse(input logic [3:0] ovr, input logic fl, input logic [3:0] dl);
    port_rx_overrun <= ovr;
    frame_loss_state <= fl;
    cell_delineation_loss_state <= dl;
    @(posedge sys_clk);
    port_rx_overrun <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask

  // read data is judged at the edge that samples ack
  always @(posedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (exp_q.size() == 0) failures++;
      else compare(wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, frame_loss_state} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 48'h0;
    {port_rx_overrun, cell_delineation_loss_state} = 8'h00;
    failures = 0;
    check_count = 0;
    r = $urandom(32'h152A45DB);
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    wb_read(rais_pkg::IDX_STATUS, 32'h0);
    wb_read(rais_pkg::IDX_ENABLE, 32'h0);
    check_irq(1'b0);
    wb_xfer(1'b1, rais_pkg::IDX_ENABLE, 32'hFFFFFFFF);
    wb_read(rais_pkg::IDX_ENABLE, 32'h3FFF);
    wb_read(10'h100, 32'h0);
    wb_xfer(1'b1, rais_pkg::IDX_STATUS, 32'h3FFF);
    wb_read(rais_pkg::IDX_STATUS, 32'h0);
    for (int c = 0; c < 4; c++) begin
      pulse(4'h1 << c, 1'b0, 4'h0);
      wb_read(rais_pkg::IDX_STATUS, 32'h1 << (rais_pkg::BIT_OVR_LO + c));
      check_irq(1'b1);
      clear_all;
      check_irq(1'b0);
      pulse(4'h0, 1'b0, 4'h1 << c);
      wb_read(rais_pkg::IDX_STATUS, 32'h1 << c);
      pulse(4'h0, 1'b0, 4'h0);
      wb_read(rais_pkg::IDX_STATUS, (32'h11 << c));
      clear_all;
    end
    pulse(4'h0, 1'b1, 4'h0);
    wb_read(rais_pkg::IDX_STATUS, 32'h100);
    clear_all;
    pulse(4'h0, 1'b0, 4'h0);
    wb_read(rais_pkg::IDX_STATUS, 32'h200);
    clear_all;
    // only the frame-loss-raised bit enabled: a masked bit must stay silent
    wb_xfer(1'b1, rais_pkg::IDX_ENABLE, 32'h100);
    pulse(4'h0, 1'b1, 4'h0);
    check_irq(1'b1);
    pulse(4'h0, 1'b0, 4'h0);
    wb_xfer(1'b1, rais_pkg::IDX_CLEAR, 32'h100);
    check_irq(1'b0);
    wb_read(rais_pkg::IDX_STATUS, 32'h200);
    clear_all;
    wb_xfer(1'b1, rais_pkg::IDX_ENABLE, 32'h3FFF);
    for (int i = 0; i < 8; i++) begin
      r = $urandom & 32'hF;
      pulse(r[3:0], 1'b0, 4'h0);
      wb_read(rais_pkg::IDX_STATUS, r << 10);
      check_irq(r != 32'h0);
      clear_all;
    end
    // concatenated mode: only channel 0 and frame loss bits may appear
    wb_xfer(1'b1, rais_pkg::IDX_CTRL, 32'h1);
    pulse(4'hF, 1'b1, 4'hF);
    wb_read(rais_pkg::IDX_CTRL, 32'h1);
    wb_read(rais_pkg::IDX_STATE, 32'h1F);
    pulse(4'hF, 1'b0, 4'h0);
    wb_read(rais_pkg::IDX_STATUS, 32'h0711);
    repeat (2) @(posedge sys_clk);
    summarize;
  end
endmodule
